/* File: rsim_pkg.sv */
/*
 * package for the shared interrupt pin priority logic of the rtc.
 * assumes one clock (mclk, 100 MHz) and an apb register slave.
 */
package rsim_pkg;

  // ------------------------------------------------------------------
  // register byte addresses
  // ------------------------------------------------------------------
  localparam logic [7:0] ADDR_DIG_CAL   = 8'h20; // index 08h
  localparam logic [7:0] ADDR_WDOG      = 8'h24; // index 09h
  localparam logic [7:0] ADDR_ALM1_MON  = 8'h28; // index 0ah
  localparam logic [7:0] ADDR_FLAGS     = 8'h3c; // index 0fh
  localparam logic [7:0] ADDR_TMR_CTL   = 8'h44; // index 11h
  localparam logic [7:0] ADDR_SRC       = 8'h80; // synchronised conditions and supply request
  localparam logic [7:0] ADDR_PIN_STAT  = 8'h84; // pin state readback

  // ------------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------------
  localparam int BIT_LEVEL      = 7; // dig cal: discrete level
  localparam int BIT_FT         = 6; // dig cal: freq test enable
  localparam int BIT_OF_IE      = 7; // wdog: osc fail irq enable
  localparam int BIT_A1_IE      = 7; // alarm1 month: alarm irq enable
  localparam int BIT_BKUP_IE    = 5; // alarm1 month: backup irq enable
  localparam int BIT_TMR_IE     = 5; // timer control: timer irq enable
  localparam int BIT_WD_LSB     = 0; // wdog: multiplier field low bit
  localparam int BIT_WD_MSB     = 4; // wdog: multiplier field high bit
  localparam int BIT_OF_FLAG    = 2; // flags: osc fail flag

  // ------------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------------
  localparam logic [7:0] RST_DIG_CAL  = 8'h80;
  localparam logic [7:0] RST_WDOG     = 8'h00;
  localparam logic [7:0] RST_ALM1_MON = 8'h00;
  localparam logic [7:0] RST_TMR_CTL  = 8'h00;
  localparam logic       RST_OF_FLAG  = 1'b1;

  // ------------------------------------------------------------------
  // timing: 512 hz test square wave from the 100 mhz clock
  // ------------------------------------------------------------------
  localparam int CLK_HZ      = 100_000_000;
  localparam int FT_HZ       = 512;
  localparam int FT_HALF_CYC = CLK_HZ / (2 * FT_HZ); // 97656 cycles

endpackage

/* File: rsim_irq_mux.sv */
/*
 * shared open-drain interrupt pin priority logic with its apb registers.
 * assumes an external pull-up on the pin, source conditions from the
 * rtc core as inputs, and power state from the switchover logic.
 */
`timescale 1ns/1ps

// Function
// - sources, test signal, level onto one pin
// - pin only pulled low or released
// - four interrupt conditions ored into request
// - selected test outputs 512 hz square
// - backup: only alarm and osc fail count
// - supply, level 0, test 0: pin low
// - supply, test 1: square if level 0/none enabled
// - supply, level 1, enabled: low on condition
// - supply, level 1, test 0, nothing enabled: released
// - backup ignores test bit entirely
// - backup, backup enable 0: released
// - backup, level 1, none enabled: released
// - backup, enable 1, level 0: low
// - backup, all set: low on condition
// - level bit7, test bit6 at 08h
// - alarm enable bit7, backup bit5 at 0ah
// - timer enable 11h bit5, osc 09h bit7
// - running watchdog counts as enabled source on supply
// - pin stays low until all cleared
// - osc fail flag sticky until written 0
// - osc enable gates flag immediately
module rsim_irq_mux #(
  parameter int FT_HALF = rsim_pkg::FT_HALF_CYC
) (
  input  wire logic        mclk,
  input  wire logic        nrst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        battery_backup,
  input  wire logic        timer_cond,
  input  wire logic        alarm_one_cond,
  input  wire logic        watchdog_cond,
  input  wire logic        osc_fail_event,
  input  wire logic        shared_irq_pin_in,
  output logic             shared_irq_pin_out,
  output logic             shared_irq_pin_oe
);

  if (FT_HALF < 1 || FT_HALF > 131072) begin : g_bad_half
    $error("rsim_irq_mux: FT_HALF outside the 17-bit counter range");
  end

  // ------------------------------------------------------------------
  // input synchronisers
  // ------------------------------------------------------------------
  logic [4:0] sync1_r;
  logic [4:0] sync2_r;
  logic       bkup_s;
  logic       tmr_s;
  logic       a1_s;
  logic       wd_s;
  logic       ofev_s;

  // two flops per external level
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      sync1_r <= 5'h00;
      sync2_r <= 5'h00;
    end else begin
      sync1_r <= {battery_backup, timer_cond, alarm_one_cond,
                  watchdog_cond, osc_fail_event};
      sync2_r <= sync1_r;
    end
  end

  assign {bkup_s, tmr_s, a1_s, wd_s, ofev_s} = sync2_r;

  // ------------------------------------------------------------------
  // apb register file
  // ------------------------------------------------------------------
  logic [7:0] dig_cal_r;
  logic [7:0] wdog_r;
  logic [7:0] alm1_mon_r;
  logic [7:0] tmr_ctl_r;
  logic       osc_fail_flag_r;
  logic       wr_en;
  logic       rd_en;
  logic       addr_ok;

  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && penable && !pwrite;
  assign addr_ok = (paddr == rsim_pkg::ADDR_DIG_CAL)  ||
                   (paddr == rsim_pkg::ADDR_WDOG)     ||
                   (paddr == rsim_pkg::ADDR_ALM1_MON) ||
                   (paddr == rsim_pkg::ADDR_FLAGS)    ||
                   (paddr == rsim_pkg::ADDR_TMR_CTL)  ||
                   (paddr == rsim_pkg::ADDR_SRC)      ||
                   (paddr == rsim_pkg::ADDR_PIN_STAT);

  // control register writes
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      dig_cal_r  <= rsim_pkg::RST_DIG_CAL;
      wdog_r     <= rsim_pkg::RST_WDOG;
      alm1_mon_r <= rsim_pkg::RST_ALM1_MON;
      tmr_ctl_r  <= rsim_pkg::RST_TMR_CTL;
    end else if (wr_en) begin
      case (paddr)
        rsim_pkg::ADDR_DIG_CAL:  dig_cal_r  <= pwdata[7:0];
        rsim_pkg::ADDR_WDOG:     wdog_r     <= pwdata[7:0];
        rsim_pkg::ADDR_ALM1_MON: alm1_mon_r <= pwdata[7:0];
        rsim_pkg::ADDR_TMR_CTL:  tmr_ctl_r  <= pwdata[7:0];
        default: ;
      endcase
    end
  end

  // sticky osc fail flag: event wins over a clearing write, reads no effect
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      osc_fail_flag_r <= rsim_pkg::RST_OF_FLAG;
    end else if (ofev_s) begin
      osc_fail_flag_r <= 1'b1;
    end else if (wr_en && paddr == rsim_pkg::ADDR_FLAGS &&
                 !pwdata[rsim_pkg::BIT_OF_FLAG]) begin
      osc_fail_flag_r <= 1'b0;
    end
  end

  // ------------------------------------------------------------------
  // enables and request
  // ------------------------------------------------------------------
  logic level_bit;
  logic ft_bit;
  logic a1_ie;
  logic of_ie;
  logic bk_ie;
  logic tm_ie;
  logic wd_run;
  logic any_en_main;
  logic any_en_bkup;
  logic req_main;
  logic req_bkup;

  assign level_bit = dig_cal_r[rsim_pkg::BIT_LEVEL];
  assign ft_bit    = dig_cal_r[rsim_pkg::BIT_FT];
  assign a1_ie     = alm1_mon_r[rsim_pkg::BIT_A1_IE];
  assign bk_ie     = alm1_mon_r[rsim_pkg::BIT_BKUP_IE];
  assign of_ie     = wdog_r[rsim_pkg::BIT_OF_IE];
  assign tm_ie     = tmr_ctl_r[rsim_pkg::BIT_TMR_IE];
  // nonzero multiplier means the watchdog runs
  assign wd_run    = |wdog_r[rsim_pkg::BIT_WD_MSB:rsim_pkg::BIT_WD_LSB];

  assign any_en_main = a1_ie || of_ie || tm_ie || wd_run;
  assign any_en_bkup = a1_ie || of_ie;
  // level-sensitive or, so later sources add no transition
  assign req_main = (tm_ie && tmr_s) || (a1_ie && a1_s) ||
                    (wd_run && wd_s) || (of_ie && osc_fail_flag_r);
  assign req_bkup = (a1_ie && a1_s) || (of_ie && osc_fail_flag_r);

  // ------------------------------------------------------------------
  // 512 hz square generator
  // ------------------------------------------------------------------
  logic [16:0] ft_cnt_r;
  logic        ft_wave_r;

  // free running half-period counter
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      ft_cnt_r  <= 17'h00000;
      ft_wave_r <= 1'b0;
    end else if (ft_cnt_r == 17'(FT_HALF - 1)) begin
      ft_cnt_r  <= 17'h00000;
      ft_wave_r <= !ft_wave_r;
    end else begin
      ft_cnt_r  <= ft_cnt_r + 17'h00001;
    end
  end

  // ------------------------------------------------------------------
  // priority tables
  // ------------------------------------------------------------------
  logic pin_level;
  logic ft_sel;

  // pin level wanted: 1 released, 0 pulled low
  always_comb begin
    ft_sel = 1'b0;
    if (bkup_s) begin
      // test bit ignored here
      if (!bk_ie)            pin_level = 1'b1;
      else if (!level_bit)   pin_level = 1'b0;
      else if (!any_en_bkup) pin_level = 1'b1;
      else                   pin_level = !req_bkup;
    end else begin
      if (ft_bit && (!level_bit || !any_en_main)) begin
        ft_sel    = 1'b1;
        pin_level = ft_wave_r;
      end else if (!level_bit) pin_level = 1'b0;
      else if (!any_en_main)   pin_level = 1'b1;
      else                     pin_level = !req_main;
    end
  end

  logic pin_oe_r;
  logic ft_sel_r;

  // open drain: output low, enable only when pulling down
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      pin_oe_r <= 1'b0;
      ft_sel_r <= 1'b0;
    end else begin
      pin_oe_r <= !pin_level;
      ft_sel_r <= ft_sel;
    end
  end

  assign shared_irq_pin_oe  = pin_oe_r;
  assign shared_irq_pin_out = 1'b0;

  // ------------------------------------------------------------------
  // read data and response
  // ------------------------------------------------------------------
  logic [1:0] pin_in_sync_r;
  logic [31:0] rd_mux;

  // pin readback synchroniser
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) pin_in_sync_r <= 2'b11;
    else       pin_in_sync_r <= {pin_in_sync_r[0], shared_irq_pin_in};
  end

  always_comb begin
    rd_mux = 32'h00000000;
    unique case (paddr)
      rsim_pkg::ADDR_DIG_CAL:  rd_mux = {24'h000000, dig_cal_r};
      rsim_pkg::ADDR_WDOG:     rd_mux = {24'h000000, wdog_r};
      rsim_pkg::ADDR_ALM1_MON: rd_mux = {24'h000000, alm1_mon_r};
      rsim_pkg::ADDR_TMR_CTL:  rd_mux = {24'h000000, tmr_ctl_r};
      rsim_pkg::ADDR_FLAGS:    rd_mux = {29'h0000000, osc_fail_flag_r,
                                         2'h0};
      rsim_pkg::ADDR_SRC:      rd_mux = {27'h0000000, bkup_s, tmr_s,
                                         a1_s, wd_s, req_main};
      rsim_pkg::ADDR_PIN_STAT: rd_mux = {29'h0000000, ft_sel_r,
                                         pin_oe_r, pin_in_sync_r[1]};
      default:                 rd_mux = 32'h00000000;
    endcase
  end

  // zero wait state; error on unmapped address
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      prdata  <= 32'h00000000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !addr_ok;
      if (psel && !penable && !pwrite) prdata <= rd_mux;
    end
  end

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  default clocking cb_chk @(posedge mclk);
  endclocking

  default disable iff (!nrst);

  // request pending while the interrupt table drives the pin
  sequence s_irq_low;
    !bkup_s && level_bit && !ft_bit && any_en_main && req_main;
  endsequence

  // osc enable turned on again while its flag is still set
  sequence s_of_rearm;
    !of_ie ##1 (of_ie && osc_fail_flag_r && !bkup_s && level_bit && !ft_bit);
  endsequence

  chk_main_low_level: assert property (
    (!bkup_s && !level_bit && !ft_bit) |=> shared_irq_pin_oe)
    else $error("pin not low with level 0 on supply");

  chk_bkup_release: assert property (
    (bkup_s && !bk_ie) |=> !shared_irq_pin_oe)
    else $error("pin not released in backup with enable 0");

  chk_bkup_level_low: assert property (
    (bkup_s && bk_ie && !level_bit) |=> shared_irq_pin_oe)
    else $error("pin not low in backup with level 0");

  chk_main_idle_high: assert property (
    (!bkup_s && level_bit && !ft_bit && !any_en_main)
      |=> !shared_irq_pin_oe)
    else $error("pin not released with nothing enabled");

  chk_bkup_no_ft: assert property (
    bkup_s |=> !ft_sel_r)
    else $error("test signal selected in backup");

  chk_irq_follow: assert property (
    (!bkup_s && level_bit && any_en_main && !ft_bit)
      |=> (shared_irq_pin_oe == $past(req_main)))
    else $error("pin does not follow request on supply");

  chk_bkup_irq: assert property (
    (bkup_s && bk_ie && level_bit && any_en_bkup)
      |=> (shared_irq_pin_oe == $past(req_bkup)))
    else $error("pin does not follow request in backup");

  chk_bkup_tmr_off: assert property (
    (bkup_s && level_bit && bk_ie && !a1_s && !osc_fail_flag_r)
      |=> !shared_irq_pin_oe)
    else $error("timer or watchdog active in backup");

  chk_of_sticky: assert property (
    (osc_fail_flag_r && !(wr_en && paddr == rsim_pkg::ADDR_FLAGS))
      |=> osc_fail_flag_r)
    else $error("osc fail flag lost without write");

  chk_ft_main: assert property (
    (!bkup_s && ft_bit && !level_bit) |=> ft_sel_r)
    else $error("test signal not selected");

  chk_never_drive_hi: assert property (
    !shared_irq_pin_out)
    else $error("pin driven high");

  chk_bkup_none_en: assert property (
    (bkup_s && bk_ie && level_bit && !any_en_bkup)
      |=> !shared_irq_pin_oe)
    else $error("pin not released in backup with nothing enabled");

  chk_of_rearm: assert property (
    s_of_rearm |=> shared_irq_pin_oe)
    else $error("pin not low when osc enable set with flag pending");

  chk_irq_hold: assert property (
    s_irq_low ##1 s_irq_low |=> $stable(shared_irq_pin_oe))
    else $error("pin moved while a request stayed pending");

  chk_ft_follow: assert property (
    ft_sel_r |-> (shared_irq_pin_oe == !$past(ft_wave_r)))
    else $error("pin does not follow the test square");

  chk_ft_toggle: assert property (
    (ft_cnt_r == 17'(FT_HALF - 1))
      |=> (ft_wave_r != $past(ft_wave_r)))
    else $error("test square missed its half period toggle");

endmodule

/* File: rsim_host_pin.sv */
/*
 * host side of the shared interrupt pin: the interrupt input of the host
 * processor together with the board pull-up on that net.
 * assumes the device only pulls low (out 0 with oe 1) or lets go.
 */
`timescale 1ns/1ps

module rsim_host_pin (
  input  wire logic shared_irq_pin_out,
  input  wire logic shared_irq_pin_oe,
  output wire logic pin_level
);
  // ------------------------------------------------------------------
  // wired net
  // ------------------------------------------------------------------
  // pull-up wins whenever the device is not driving the net
  assign pin_level = (shared_irq_pin_oe === 1'b1) ? shared_irq_pin_out
                                                  : 1'b1;
endmodule

/* File: tb.sv */
/*
 * self-checking bench for the shared interrupt pin priority logic.
 * assumes zero-wait apb answers may stretch, a 4-cycle test half period,
 * and the host pin model with its pull-up on the far side.
 */
`timescale 1ns/1ps

module tb;
  // ------------------------------------------------------------------
  // signals
  // ------------------------------------------------------------------
  localparam int HALF = 4;
  logic        mclk, nrst, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        battery_backup, timer_cond, alarm_one_cond;
  logic        watchdog_cond, osc_fail_event, pin_out, pin_oe, err, prev;
  wire         pin_level;
  int          n_errors, check_count, rises, r0;

  rsim_irq_mux #(.FT_HALF(HALF)) u_dut (
    .mclk(mclk), .nrst(nrst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .battery_backup(battery_backup),
    .timer_cond(timer_cond), .alarm_one_cond(alarm_one_cond),
    .watchdog_cond(watchdog_cond), .osc_fail_event(osc_fail_event),
    .shared_irq_pin_in(pin_level), .shared_irq_pin_out(pin_out),
    .shared_irq_pin_oe(pin_oe));

  rsim_host_pin u_host (
    .shared_irq_pin_out(pin_out), .shared_irq_pin_oe(pin_oe),
    .pin_level(pin_level));

  // ------------------------------------------------------------------
  // clock and pin edge counter
  // ------------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // counts rising edges of the pin as seen by the host
  always @(posedge mclk) begin
    prev <= pin_level;
    if (pin_level === 1'b1 && prev === 1'b0) rises <= rises + 1;
  end

  // ------------------------------------------------------------------
  // checking and apb tasks
  // ------------------------------------------------------------------
  task automatic print_verdict();
    if (n_errors == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic chk_word(input string nm, input logic [31:0] e, g);
    check_count++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk_bit(input string nm, input logic e, g);
    check_count++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] %s expected %b seen %b", nm, e, g);
    end
  endtask

  // one transfer: setup, access until pready, release, one idle edge
  task automatic apb(input logic [7:0] a, input logic w, input logic [7:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1 && n < 50) begin
      @(posedge mclk);
      n++;
    end
    if (n == 50) begin
      n_errors++;
      print_verdict();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(a, 1'b1, d);
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    apb(a, 1'b0, 8'h00);
    chk_word("read data", e, rd);
  endtask

  // pin level after inputs had time to pass the synchronisers
  task automatic pin_is(input logic e);
    repeat (6) @(posedge mclk);
    chk_bit("pin level", e, pin_level);
  endtask

  // rising edges over 32 cycles once the pin settled: 4 for a square
  task automatic sq(input int e);
    repeat (2) @(posedge mclk);
    r0 = rises;
    repeat (32) @(posedge mclk);
    chk_word("square rises", e, rises - r0);
  endtask

  // enable one source: 0 timer, 1 alarm, 2 watchdog, 3 osc fail
  task automatic src(input int i, input logic on);
    case (i)
      0: wr(rsim_pkg::ADDR_TMR_CTL, on ? 8'h20 : 8'h00);
      1: wr(rsim_pkg::ADDR_ALM1_MON, on ? 8'h80 : 8'h00);
      2: wr(rsim_pkg::ADDR_WDOG, on ? 8'h01 : 8'h00);
      default: wr(rsim_pkg::ADDR_WDOG, on ? 8'h80 : 8'h00);
    endcase
  endtask

  // raise or clear one condition; the osc flag is cleared by a write
  task automatic cond(input int i, input logic v);
    case (i)
      0: timer_cond <= v;
      1: alarm_one_cond <= v;
      2: watchdog_cond <= v;
      default: osc_fail_event <= v;
    endcase
    if (i == 3 && !v) begin
      repeat (4) @(posedge mclk);
      wr(rsim_pkg::ADDR_FLAGS, 8'h00);
    end
  endtask

  // ------------------------------------------------------------------
  // watchdog on the whole run
  // ------------------------------------------------------------------
  initial begin
    repeat (20000) @(posedge mclk);
    n_errors++;
    print_verdict();
  end

  // ------------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------------
  initial begin
    n_errors = 0;
    check_count = 0;
    rises = 0;
    prev = 1'b1;
    {nrst, psel, penable, pwrite, battery_backup} = '0;
    {timer_cond, alarm_one_cond, watchdog_cond, osc_fail_event} = '0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (8) @(posedge mclk);
    nrst <= 1'b1;
    @(posedge mclk);
    // reset state and register layout
    rdchk(rsim_pkg::ADDR_DIG_CAL, 32'h80);
    rdchk(rsim_pkg::ADDR_WDOG, 32'h00);
    rdchk(rsim_pkg::ADDR_ALM1_MON, 32'h00);
    apb(rsim_pkg::ADDR_FLAGS, 1'b0, 8'h00);
    chk_word("osc flag", 32'h4, rd & 32'h4);
    chk_bit("slverr", 1'b0, err);
    pin_is(1'b1);
    chk_bit("pin drive", 1'b0, pin_out);
    rdchk(rsim_pkg::ADDR_PIN_STAT, 32'h1);
    apb(8'h10, 1'b0, 8'h00);
    chk_bit("slverr", 1'b1, err);
    chk_word("unmapped", 32'h0, rd);
    wr(rsim_pkg::ADDR_FLAGS, 8'h00);
    // supply: level 0 dominates, test square wins as tabled
    src(0, 1'b1);
    rdchk(rsim_pkg::ADDR_TMR_CTL, 32'h20);
    wr(rsim_pkg::ADDR_DIG_CAL, 8'h00);
    pin_is(1'b0);
    sq(0);
    wr(rsim_pkg::ADDR_DIG_CAL, 8'h40);
    sq(4);
    wr(rsim_pkg::ADDR_DIG_CAL, 8'hc0);
    sq(0);
    src(0, 1'b0);
    sq(4);
    wr(rsim_pkg::ADDR_DIG_CAL, 8'h80);
    // each source: high while enabled and idle, low on its condition
    for (int i = 0; i < 4; i++) begin
      src(i, 1'b1);
      pin_is(1'b1);
      cond(i, 1'b1);
      pin_is(1'b0);
      cond(i, 1'b0);
      pin_is(1'b1);
      src(i, 1'b0);
    end
    // two pending sources: one falling edge, release after both served
    src(0, 1'b1);
    wr(rsim_pkg::ADDR_ALM1_MON, 8'h80);
    r0 = rises;
    cond(1, 1'b1);
    pin_is(1'b0);
    cond(0, 1'b1);
    pin_is(1'b0);
    cond(1, 1'b0);
    pin_is(1'b0);
    cond(0, 1'b0);
    pin_is(1'b1);
    chk_word("pin rises", 32'd1, rises - r0);
    src(0, 1'b0);
    wr(rsim_pkg::ADDR_ALM1_MON, 8'h00);
    // sticky osc flag and its enable
    src(3, 1'b1);
    osc_fail_event <= 1'b1;
    repeat (4) @(posedge mclk);
    osc_fail_event <= 1'b0;
    pin_is(1'b0);
    apb(rsim_pkg::ADDR_FLAGS, 1'b0, 8'h00);
    apb(rsim_pkg::ADDR_FLAGS, 1'b0, 8'h00);
    chk_word("osc flag", 32'h4, rd & 32'h4);
    pin_is(1'b0);
    src(3, 1'b0);
    pin_is(1'b1);
    src(3, 1'b1);
    @(posedge mclk);
    chk_bit("pin level", 1'b0, pin_level);
    wr(rsim_pkg::ADDR_FLAGS, 8'h00);
    pin_is(1'b1);
    src(3, 1'b0);
    // backup table
    wr(rsim_pkg::ADDR_DIG_CAL, 8'h00);
    pin_is(1'b0);
    battery_backup <= 1'b1;
    pin_is(1'b1);
    wr(rsim_pkg::ADDR_ALM1_MON, 8'h20);
    pin_is(1'b0);
    wr(rsim_pkg::ADDR_DIG_CAL, 8'hc0);
    src(0, 1'b1);
    src(2, 1'b1);
    cond(0, 1'b1);
    cond(2, 1'b1);
    pin_is(1'b1);
    sq(0);
    battery_backup <= 1'b0;
    pin_is(1'b0);
    battery_backup <= 1'b1;
    cond(0, 1'b0);
    cond(2, 1'b0);
    src(0, 1'b0);
    src(2, 1'b0);
    wr(rsim_pkg::ADDR_ALM1_MON, 8'ha0);
    pin_is(1'b1);
    src(0, 1'b1);
    cond(0, 1'b1);
    pin_is(1'b1);
    cond(1, 1'b1);
    pin_is(1'b0);
    wr(rsim_pkg::ADDR_ALM1_MON, 8'h80);
    pin_is(1'b1);
    cond(1, 1'b0);
    print_verdict();
  end
endmodule
